//--- rtl/tap_front_end.sv
// test access port controller with instruction, id and bypass registers
`timescale 1ns/10ps
`default_nettype none
`include "tap_map.svh"

// Notes on behaviour
// R1: sixteen-state controller moved only by test clock and mode select
// R2: instruction or selected data register forms the path from data in to out
// R3: loaded instruction picks the data register and its capture, shift, update
// R4: id, bypass and boundary-scan registers serve board test
// R5: programming interface chain reachable through the port
// R6: internal and breakpoint scan chains serve on-chip debug only
// R7: the tester drives mode select to walk the controller
// R8: all port activity follows the test clock edges
// R9: serial data in shifts into the register on the path
// R10: serial data out shows the bits leaving the selected register
// R11: no test reset pin; reset comes from mode select or power-on
// R12: fuse unprogrammed gives ordinary pins and holds the controller in reset
// R13: port enabled pulls inputs high and opens scan and programming access
// R14: data out is driven only while shifting, floating otherwise
// R15: fuse ships programmed so the port is active unless disabled
// R16: the debugger watches the system reset pin
// R17: the debugger may pull reset low only with open-collector drivers; the tester drives rst_pull_o high into an OR with the active-high reset
// R18: each transition uses mode select sampled on the test clock rising edge
// R19: power-on reset starts the controller in test-logic-reset
// R20: every shift register moves its least significant bit first
// R21: instruction register is four bits and captures 0x01
// R22: data out changes on the test clock falling edge
// R23: bypass register is one bit, one test clock of delay
module tap_front_end #(
    parameter logic [`TAP_ID_W-1:0] ID_CODE = 32'h0A5A_5001 // arbitrary value
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic                 tck_i,
    input  wire logic                 tms_i,
    input  wire logic                 tdi_i,
    input  wire logic                 test_port_enable_fuse_erased_i,
    input  wire logic                 test_port_disable_bit_i,
    input  wire tap_pkg::tap_ext_t    chain_tdo_i,
    output logic                      tdo_o,
    output logic                      tdo_oe_o,
    output logic                      pullup_en_o,
    output logic                      port_gpio_mode_o,
    output var tap_pkg::tap_state_t   tap_state_o,
    output logic [`TAP_IR_W-1:0]      instr_o,
    output var tap_pkg::tap_ext_t     chain_sel_o,
    output var tap_pkg::tap_dr_ctl_t  dr_ctl_o
);
    import tap_pkg::*;

    localparam tap_st_t ST_RST = '{
        en:       1'b0,
        tck_prev: 1'b0,
        state:    TAP_TLR,
        ir:       `TAP_OP_IDCODE,
        ir_sr:    `TAP_IR_CAPTURE,
        sel:      '{id: 1'b1, byp: 1'b0, ext: '0},
        id_sr:    '0,
        byp:      1'b0,
        tdo:      1'b0,
        tdo_oe:   1'b0,
        dr_ctl:   '0
    };

    tap_pins_t pins_raw;
    tap_pins_t pins;
    tap_st_t   q;
    tap_st_t   d;
    logic      port_en;
    logic      rise;
    logic      fall;
    logic      ext_any;
    logic      dr_bit;
    tap_sel_t  upd_sel;

    assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i};

    tap_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .pins_i    (pins_raw),
        .pins_o    (pins)
    );

    assign port_en = ~test_port_enable_fuse_erased_i & ~test_port_disable_bit_i; // R15
    assign rise    = pins.tck & ~q.tck_prev; // R8
    assign fall    = ~pins.tck & q.tck_prev; // R8
    assign ext_any = |q.sel.ext;
    assign upd_sel = tap_decode(q.ir_sr);
    assign dr_bit  = q.sel.id  ? q.id_sr[0] :
                     q.sel.byp ? q.byp : |(q.sel.ext & chain_tdo_i); // R2

    always_comb begin
        d          = q;
        d.en       = port_en; // R13
        d.tck_prev = pins.tck;
        d.dr_ctl   = '0;
        d.dr_ctl.tdi = pins.tdi;
        if (!port_en) begin
            d.state  = TAP_TLR; // R12
            d.ir     = `TAP_OP_IDCODE;
            d.sel    = tap_decode(`TAP_OP_IDCODE);
            d.tdo    = 1'b0;
            d.tdo_oe = 1'b0;
        end else begin
            if (rise) begin
                unique case (q.state)
                    TAP_TLR: begin
                        d.ir  = `TAP_OP_IDCODE; // R11
                        d.sel = tap_decode(`TAP_OP_IDCODE);
                    end
                    TAP_CAP_IR: begin
                        d.ir_sr = `TAP_IR_CAPTURE; // R21
                    end
                    TAP_SH_IR: begin
                        d.ir_sr = {pins.tdi, q.ir_sr[`TAP_IR_W-1:1]}; // R9 R20
                    end
                    TAP_UPD_IR: begin
                        d.ir  = q.ir_sr; // R3
                        d.sel = tap_decode(q.ir_sr); // R3 R5 R6
                    end
                    TAP_CAP_DR: begin
                        d.id_sr          = ID_CODE; // R4
                        d.byp            = 1'b0; // R23
                        d.dr_ctl.capture = ext_any; // R3 R5 R6
                    end
                    TAP_SH_DR: begin
                        d.id_sr        = {pins.tdi, q.id_sr[`TAP_ID_W-1:1]}; // R9 R20
                        d.byp          = pins.tdi; // R23
                        d.dr_ctl.shift = ext_any; // R9
                    end
                    TAP_UPD_DR: begin
                        d.dr_ctl.update = ext_any; // R3
                    end
                    TAP_RTI, TAP_SEL_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
                    TAP_SEL_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR: begin
                        d.ir_sr = q.ir_sr;
                    end
                endcase
                d.state = tap_next(q.state, pins.tms); // R1 R7 R18
            end
            if (fall) begin
                d.tdo_oe = (q.state == TAP_SH_IR) || (q.state == TAP_SH_DR); // R14
                d.tdo    = (q.state == TAP_SH_IR) ? q.ir_sr[0] : dr_bit; // R10 R22
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q <= ST_RST; // R19
        end else begin
            q <= d;
        end
    end

    assign tdo_o            = q.tdo;
    assign tdo_oe_o         = q.tdo_oe;
    assign pullup_en_o      = q.en; // R13
    assign port_gpio_mode_o = ~q.en; // R12
    assign tap_state_o      = q.state;
    assign instr_o          = q.ir;
    assign chain_sel_o      = q.sel.ext;
    assign dr_ctl_o         = q.dr_ctl;

    // helper: consecutive rising edges with mode select high
    logic [2:0] ones_q;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ones_q <= `TAP_ONES_RESET;
        end else if (!port_en) begin
            ones_q <= `TAP_ONES_RESET;
        end else if (rise) begin
            if (!pins.tms) begin
                ones_q <= 3'h0;
            end else if (ones_q != `TAP_ONES_RESET) begin
                ones_q <= ones_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_rise_in(tap_state_t st);
        rise && port_en && q.state == st;
    endsequence

    sequence s_fall_in(tap_state_t st);
        fall && port_en && q.state == st;
    endsequence

    AST_HELD_RESET: assert property ( // R12
        !port_en |=> q.state == TAP_TLR && !tdo_oe_o && port_gpio_mode_o)
        else $error("controller not held in reset while port disabled");

    AST_FIVE_ONES_TLR: assert property ( // R18
        ones_q == `TAP_ONES_RESET |-> q.state == TAP_TLR)
        else $error("five mode-select ones did not reach test-logic-reset");

    AST_STATE_ON_RISE_ONLY: assert property ( // R8
        !rise && port_en && $past(port_en) |=> q.state == $past(q.state))
        else $error("controller moved without a test clock rising edge");

    AST_OE_ONLY_SHIFT: assert property ( // R14
        tdo_oe_o |-> q.state inside {TAP_SH_IR, TAP_SH_DR, TAP_EX1_IR, TAP_EX1_DR})
        else $error("data out driven outside shifting");

    AST_IR_CAPTURE: assert property ( // R21
        s_rise_in(TAP_CAP_IR) |=> q.ir_sr == `TAP_IR_CAPTURE && q.state != TAP_CAP_IR)
        else $error("instruction capture value wrong");

    AST_IR_SHIFT_LSB: assert property ( // R20
        s_rise_in(TAP_SH_IR) |=>
            q.ir_sr[3] == $past(pins.tdi) && q.ir_sr[2:0] == $past(q.ir_sr[3:1]))
        else $error("instruction shift order wrong");

    AST_IR_UPDATE: assert property ( // R3
        s_rise_in(TAP_UPD_IR) |=> instr_o == $past(q.ir_sr) && chain_sel_o == $past(upd_sel.ext))
        else $error("instruction not updated");

    AST_BYPASS_DELAY: assert property ( // R23
        s_rise_in(TAP_SH_DR) ##0 q.sel.byp |=> q.byp == $past(pins.tdi))
        else $error("bypass bit did not take data in");

    AST_TDO_IR_FALL: assert property ( // R22
        s_fall_in(TAP_SH_IR) |=> tdo_oe_o && tdo_o == $past(q.ir_sr[0]))
        else $error("data out did not follow instruction lsb on falling edge");

    AST_TDO_ID_FALL: assert property ( // R10
        s_fall_in(TAP_SH_DR) ##0 q.sel.id |=> tdo_o == $past(q.id_sr[0]))
        else $error("data out did not follow id register lsb");

    AST_EXT_SHIFT_PULSE: assert property ( // R5
        s_rise_in(TAP_SH_DR) ##0 ext_any |=> dr_ctl_o.shift ##1 !dr_ctl_o.shift)
        else $error("external chain shift strobe not one cycle");

endmodule

`default_nettype wire

//--- shared/tap_map.svh
// constants of the test access port front end
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

`define TAP_IR_W        4
`define TAP_ID_W        32
`define TAP_IR_CAPTURE  4'h1
`define TAP_OP_EXTEST   4'h0
`define TAP_OP_IDCODE   4'h1
`define TAP_OP_SAMPLE   4'h2
`define TAP_OP_PROG_LO  4'h4
`define TAP_OP_PROG_HI  4'h7
`define TAP_OP_PRIV0    4'h8
`define TAP_OP_PRIV1    4'h9
`define TAP_OP_PRIV2    4'hA
`define TAP_OP_PRIV3    4'hB
`define TAP_OP_BYPASS   4'hF
`define TAP_ONES_RESET  3'h5

`endif

//--- shared/tap_pkg.sv
// types and helper functions of the test access port front end
`include "tap_map.svh"

package tap_pkg;

    typedef enum logic [3:0] {
        TAP_TLR    = 4'b1111,
        TAP_RTI    = 4'b1100,
        TAP_SEL_DR = 4'b0111,
        TAP_CAP_DR = 4'b0110,
        TAP_SH_DR  = 4'b0010,
        TAP_EX1_DR = 4'b0001,
        TAP_PAU_DR = 4'b0011,
        TAP_EX2_DR = 4'b0000,
        TAP_UPD_DR = 4'b0101,
        TAP_SEL_IR = 4'b0100,
        TAP_CAP_IR = 4'b1110,
        TAP_SH_IR  = 4'b1010,
        TAP_EX1_IR = 4'b1001,
        TAP_PAU_IR = 4'b1011,
        TAP_EX2_IR = 4'b1000,
        TAP_UPD_IR = 4'b1101
    } tap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;

    typedef struct packed {
        tap_pins_t meta;
        tap_pins_t sync;
    } tap_sync_st_t;

    typedef struct packed {
        logic bscan;
        logic prog;
        logic int_scan;
        logic bkpt;
    } tap_ext_t;

    typedef struct packed {
        logic     id;
        logic     byp;
        tap_ext_t ext;
    } tap_sel_t;

    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
        logic tdi;
    } tap_dr_ctl_t;

    typedef struct packed {
        logic                  en;
        logic                  tck_prev;
        tap_state_t            state;
        logic [`TAP_IR_W-1:0]  ir;
        logic [`TAP_IR_W-1:0]  ir_sr;
        tap_sel_t              sel;
        logic [`TAP_ID_W-1:0]  id_sr;
        logic                  byp;
        logic                  tdo;
        logic                  tdo_oe;
        tap_dr_ctl_t           dr_ctl;
    } tap_st_t;

    function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
        tap_state_t n;
        n = s;
        unique case (s)
            TAP_TLR:    n = tms ? TAP_TLR    : TAP_RTI;
            TAP_RTI:    n = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  n = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: n = tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: n = tms ? TAP_TLR    : TAP_CAP_IR;
            TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  n = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: n = tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_RTI;
        endcase
        return n;
    endfunction

    function automatic tap_sel_t tap_decode(input logic [`TAP_IR_W-1:0] ir);
        tap_sel_t s;
        s = '0;
        if (ir == `TAP_OP_EXTEST || ir == `TAP_OP_SAMPLE) begin
            s.ext.bscan = 1'b1;
        end else if (ir == `TAP_OP_IDCODE) begin
            s.id = 1'b1;
        end else if (ir >= `TAP_OP_PROG_LO && ir <= `TAP_OP_PROG_HI) begin
            s.ext.prog = 1'b1;
        end else if (ir == `TAP_OP_PRIV0 || ir == `TAP_OP_PRIV2) begin
            s.ext.int_scan = 1'b1;
        end else if (ir == `TAP_OP_PRIV1 || ir == `TAP_OP_PRIV3) begin
            s.ext.bkpt = 1'b1;
        end else begin
            s.byp = 1'b1;
        end
        return s;
    endfunction

endpackage

//--- rtl/tap_sync.sv
// two-stage synchroniser for the test port pins
`timescale 1ns/10ps
`default_nettype none

module tap_sync (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire tap_pkg::tap_pins_t pins_i,
    output var  tap_pkg::tap_pins_t pins_o
);
    import tap_pkg::*;

    tap_sync_st_t q;
    tap_sync_st_t d;

    always_comb begin
        d      = q;
        d.meta = pins_i;
        d.sync = q.meta;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pins_o = q.sync;

endmodule

`default_nettype wire

//--- testbench/tap_tester.sv
// behavioural tester that drives the test port pins
`timescale 1ns/10ps
`default_nettype none

module tap_tester (
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    input  wire logic sys_rst_i,
    output var  logic tck_o,
    output var  logic tms_o,
    output var  logic tdi_o,
    output var  logic rst_pull_o
);
    // board pull-up on data out while the port floats it
    wire logic tdo_pin = tdo_oe_i ? tdo_i : 1'b1;

    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        rst_pull_o = 1'b0;
    end

    // debugger watch on the system reset line: counts releases
    int resets_seen = 0;

    always @(negedge sys_rst_i) begin
        resets_seen <= resets_seen + 1;
    end

    // the reset line is wired-or, so the debugger may pull it
    task automatic pull_reset();
        rst_pull_o <= 1'b1;
        #35;
        rst_pull_o <= 1'b0;
    endtask

    // one test clock; the clock stands low between calls
    task automatic bit_io(input logic tms, input logic tdi, output logic tdo, output logic oe);
        tms_o <= tms;
        tdi_o <= tdi;
        #62.5;
        tck_o <= 1'b1;
        tdo = tdo_pin;
        oe = tdo_oe_i;
        #62.5;
        tck_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- testbench/test_access_port_front_end_tb_top.sv
// self-checking bench of the test access port front end
`timescale 1ns/10ps
`default_nettype none

module test_access_port_front_end_tb_top;
    import tap_pkg::*;
    localparam logic [31:0] TB_ID = 32'h3C96_0E11; // arbitrary value
    logic        clk;
    logic        rst;
    logic        rst_pull;
    wire logic   rst_line = rst | rst_pull;
    logic [1:0]  sh_log = '0;
    logic        fuse_erased;
    logic        port_off;
    tap_ext_t    chain_tdo;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo;
    logic        tdo_oe;
    logic        pullup_en;
    logic        gpio_mode;
    tap_state_t  state;
    logic [3:0]  instr;
    tap_ext_t    chain_sel;
    tap_dr_ctl_t dr_ctl;
    int          miscompares = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          n_cap = 0;
    int          n_sh = 0;
    int          n_upd = 0;

    tap_front_end #(.ID_CODE(TB_ID)) uut (
        .clk_sys_i(clk), .rst_i(rst_line), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .test_port_enable_fuse_erased_i(fuse_erased), .test_port_disable_bit_i(port_off),
        .chain_tdo_i(chain_tdo), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pullup_en_o(pullup_en),
        .port_gpio_mode_o(gpio_mode), .tap_state_o(state), .instr_o(instr),
        .chain_sel_o(chain_sel), .dr_ctl_o(dr_ctl)
    );

    tap_tester tester (.tdo_i(tdo), .tdo_oe_i(tdo_oe), .sys_rst_i(rst_line), .tck_o(tck),
                       .tms_o(tms), .tdi_o(tdi), .rst_pull_o(rst_pull));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // counts chain strobes and cuts a hang short
    always @(negedge clk) begin
        cycles <= cycles + 1;
        if (dr_ctl.capture === 1'b1) n_cap <= n_cap + 1;
        if (dr_ctl.shift === 1'b1) n_sh <= n_sh + 1;
        if (dr_ctl.shift === 1'b1) sh_log <= {sh_log[0], dr_ctl.tdi};
        if (dr_ctl.update === 1'b1) n_upd <= n_upd + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            finish_test();
        end
    end

    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [3:0] exp_sel(input logic [3:0] op);
        case (op)
            4'h0, 4'h2: return 4'h8;
            4'h4, 4'h5, 4'h6, 4'h7: return 4'h4;
            4'h8, 4'hA: return 4'h2;
            4'h9, 4'hB: return 4'h1;
            default: return 4'h0;
        endcase
    endfunction

    task automatic step(input logic m);
        logic t;
        logic o;
        tester.bit_io(m, 1'b0, t, o);
    endtask

    // full scan from idle back to idle
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout, output logic oe_all);
        logic t;
        logic o;
        oe_all = 1'b1;
        dout = '0;
        step(1'b1);
        if (ir) step(1'b1);
        step(1'b0);
        step(1'b0);
        for (int i = 0; i < n; i++) begin
            tester.bit_io(i == n - 1, din[i], t, o);
            dout[i] = t;
            oe_all &= o;
        end
        step(1'b1);
        step(1'b0);
        repeat (8) @(posedge clk);
    endtask

    task automatic t_reset();
        cmp_vec(32'(state), 32'(TAP_TLR));
        cmp_vec(32'(instr), 32'h1);
        cmp_bit(tdo_oe, 1'b0);
        cmp_bit(pullup_en, 1'b1);
        cmp_bit(gpio_mode, 1'b0);
        cmp_vec(32'(tester.resets_seen), 32'h1);
        step(1'b0);
        repeat (8) @(posedge clk);
        cmp_vec(32'(state), 32'(TAP_RTI));
        $display("test reset done");
    endtask

    task automatic t_ir_capture();
        logic [31:0] d;
        logic oe;
        scan(1'b1, 32'hF, 4, d, oe);
        cmp_vec(d, 32'h1);
        cmp_bit(oe, 1'b1);
        cmp_bit(tdo_oe, 1'b0);
        cmp_vec(32'(instr), 32'hF);
        $display("test ir capture done");
    endtask

    task automatic t_bypass();
        logic [31:0] d;
        logic oe;
        scan(1'b0, 32'hB5, 8, d, oe);
        cmp_vec(d, 32'h6A);
        $display("test bypass done");
    endtask

    task automatic t_five_ones();
        repeat (5) step(1'b1);
        repeat (8) @(posedge clk);
        cmp_vec(32'(state), 32'(TAP_TLR));
        cmp_vec(32'(instr), 32'h1);
        step(1'b0);
        repeat (8) @(posedge clk);
        $display("test five ones done");
    endtask

    task automatic t_idcode();
        logic [31:0] d;
        logic oe;
        scan(1'b0, 32'h0, 32, d, oe);
        cmp_vec(d, TB_ID);
        $display("test idcode done");
    endtask

    task automatic t_opcodes();
        logic [31:0] d;
        logic [31:0] e;
        logic oe;
        int c;
        for (int op = 0; op < 16; op++) begin
            @(posedge clk);
            chain_tdo <= tap_ext_t'(exp_sel(4'(op)));
            scan(1'b1, op, 4, d, oe);
            cmp_vec(32'(instr), op);
            cmp_vec(32'(chain_sel), 32'(exp_sel(4'(op))));
            c = n_cap * 100 + n_sh * 10 + n_upd;
            scan(1'b0, 32'h1, 2, d, oe);
            e = (op == 1) ? {30'h0, TB_ID[1:0]} : 32'h2;
            if (exp_sel(4'(op)) != 4'h0) e = 32'h3;
            cmp_vec(d, e);
            if (exp_sel(4'(op)) != 4'h0) cmp_vec(32'(sh_log), 32'h2);
            e = (exp_sel(4'(op)) != 4'h0) ? 32'd121 : 32'd0;
            cmp_vec(n_cap * 100 + n_sh * 10 + n_upd - c, e);
        end
        chain_tdo <= '0;
        $display("test opcodes done");
    endtask

    task automatic t_port_off(input logic fuse);
        @(posedge clk);
        if (fuse) fuse_erased <= 1'b1;
        else port_off <= 1'b1;
        repeat (6) @(posedge clk);
        cmp_bit(gpio_mode, 1'b1);
        cmp_bit(pullup_en, 1'b0);
        cmp_bit(tdo_oe, 1'b0);
        step(1'b0);
        step(1'b0);
        repeat (8) @(posedge clk);
        cmp_vec(32'(state), 32'(TAP_TLR));
        fuse_erased <= 1'b0;
        port_off <= 1'b0;
        repeat (6) @(posedge clk);
        cmp_bit(pullup_en, 1'b1);
        step(1'b0);
        repeat (8) @(posedge clk);
        cmp_vec(32'(state), 32'(TAP_RTI));
        $display("test port off done");
    endtask

    task automatic t_mid_reset();
        logic [31:0] d;
        logic oe;
        scan(1'b1, 32'hF, 4, d, oe);
        cmp_vec(32'(instr), 32'hF);
        @(posedge clk);
        tester.pull_reset();
        repeat (6) @(posedge clk);
        cmp_vec(32'(tester.resets_seen), 32'h2);
        cmp_vec(32'(state), 32'(TAP_TLR));
        cmp_vec(32'(instr), 32'h1);
        cmp_vec(32'(chain_sel), 32'h0);
        cmp_bit(tdo_oe, 1'b0);
        step(1'b0);
        repeat (8) @(posedge clk);
        cmp_vec(32'(state), 32'(TAP_RTI));
        $display("test mid reset done");
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        fuse_erased = 1'b0;
        port_off = 1'b0;
        chain_tdo = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset();
        t_ir_capture();
        t_bypass();
        t_five_ones();
        t_idcode();
        t_opcodes();
        t_port_off(1'b0);
        t_port_off(1'b1);
        t_mid_reset();
        finish_test();
    end
endmodule

`default_nettype wire
